// File: mnt_desc_match.sv
`timescale 1ns/1ns
`include "mnt_map.svh"

// ==========================================
// One descriptor: range and space compare, physical address forming
module mnt_desc_match (
    input wire logic enable,
    input wire logic [`MNT_ADDR_W-1:0] addr,
    input wire logic [`MNT_SPACE_W-1:0] space,
    input wire logic [`MNT_ADDR_W-1:0] logical_base_address,
    input wire logic [`MNT_ADDR_W-1:0] logical_address_mask,
    input wire logic [`MNT_ADDR_W-1:0] physical_base_address,
    input wire logic [`MNT_SPACE_W-1:0] space_number_field,
    input wire logic [`MNT_SPACE_W-1:0] space_mask,
    output logic hit,
    output logic [`MNT_ADDR_W-1:0] phys
);
    logic range_hit;
    logic space_hit;

    // RULE3: masked range compare
    assign range_hit = ((addr ^ logical_base_address) & logical_address_mask) == '0;
    // RULE4: masked space compare
    assign space_hit = ((space ^ space_number_field) & space_mask) == '0;
    // RULE5: address match needs both
    assign hit = enable & range_hit & space_hit;
    // RULE6: base where mask set, logical where clear
    assign phys = (addr & ~logical_address_mask) | (physical_base_address & logical_address_mask);
endmodule

// File: mnt_map.svh
`ifndef MNT_MAP_SVH
`define MNT_MAP_SVH

// ==========================================
// Sizes of the translation datapath
`define MNT_N_DESC 32
`define MNT_IDX_W 5
`define MNT_ADDR_W 16
`define MNT_SPACE_W 8
`define MNT_FC_W 4
`define MNT_N_SPACE 16
`define MNT_CAUSE_W 4
`define MNT_RDP_W 8
`define MNT_CNT_W 3
`define MNT_SYNC_W 29

// ==========================================
// Reset values
`define MNT_RDP_RESET 8'h80
`define MNT_SPACE_RESET 8'h00

// ==========================================
// Cause field encodings
`define MNT_CAUSE_NONE 4'h0
`define MNT_CAUSE_WV 4'h1
`define MNT_CAUSE_USA 4'h2

// ==========================================
// Timing counts in clocks
`define MNT_FAULT_CLKS 3'h5
`define MNT_ALL_HOLD_CLKS 3'h2

`endif

// File: mnt_peer.sv
`timescale 1ns/1ns

// ==========================================
// Peer translation unit on the shared lines
module mnt_peer (
    input wire logic ref_clk,
    input wire logic as_n,
    input wire logic [1:0] mode,
    input wire logic all_line,
    output logic mas_n,
    output logic flt_n,
    output logic all_out
);
    logic [3:0] cnt;
    logic [1:0] seen;
    // Cycle age and none-matched sensing
    always_ff @(posedge ref_clk) begin
        cnt <= as_n ? 4'h0 : (cnt == 4'hF ? cnt : cnt + 4'h1);
        if (as_n) begin
            seen <= 2'h0;
        end else if ((all_line || seen != 2'h0) && seen != 2'h3) begin
            seen <= seen + 2'h1;
        end
    end
    always_ff @(posedge ref_clk) begin
        mas_n <= !(!as_n && mode == 2'h1 && cnt > 4'h7);
        flt_n <= !(!as_n && ((mode == 2'h2 && cnt > 4'h7) || seen == 2'h3));
        all_out <= !as_n && mode == 2'h3 && seen != 2'h3;
    end
endmodule

// File: mnt_pkg.sv
package mnt_pkg;
    // Translation sequencer states, Gray along the usual path
    typedef enum logic [2:0] {
        MNT_IDLE = 3'h0,
        MNT_MATCH = 3'h1,
        MNT_XLATE = 3'h3,
        MNT_FOLLOW = 3'h2,
        MNT_OPER = 3'h6,
        MNT_NOMATCH = 3'h5,
        MNT_USA = 3'h4,
        MNT_FAULT = 3'h7
    } mnt_state_t;
endpackage

// File: mnt_translate.sv
`timescale 1ns/1ns
`include "mnt_map.svh"

// Summary of operation
// RULE1: Function code indexes space lookup table to give cycle space number.
// RULE2: Address strobe starts translation; space, address, direction go to descriptors.
// RULE3: Range match when masked logical address equals logical base.
// RULE4: Space match when masked cycle space equals descriptor space number.
// RULE5: Address match needs range and space; write to protected segment violates.
// RULE6: Physical bit from base where mask set, logical where clear.
// RULE7: Success sets used, modified on write, pending when interrupt enabled.
// RULE8: Write inhibit on protected segment for read or read-modify-write.
// RULE9: Write to protected segment withholds mapped strobe.
// RULE10: Mapped strobe, then hold address, then float physical bus.
// RULE11: Strobe negated after translation returns to idle.
// RULE12: Strobe held: chip select or acknowledge starts master; global input slave.
// RULE13: Read-to-write direction fall on protected match is write violation.
// RULE14: Local violation loads pointer, sets fault and double fault flags.
// RULE15: Local violation captures direction, cause becomes write violation.
// RULE16: Fault driven five clocks or until strobe negates, whichever longer.
// RULE17: Local violation latches address and space, marked non-global.
// RULE18: No local match asserts none-matched output and watches peer lines.
// RULE19: Peer mapped strobe negates none-matched output, then continue normally.
// RULE20: Peer fault sets fault flags, captures direction, clears cause field.
// RULE21: None-matched input sets flags, cause undefined, latches address and space.
// RULE22: None-matched held two clocks, released, then fault pulse; the code releases it on the same clock that the fault pulse starts.
module mnt_translate (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic as_n,
    input wire logic rw,
    input wire logic [`MNT_FC_W-1:0] fc,
    input wire logic [`MNT_ADDR_W-1:0] laddr,
    input wire logic cs_n,
    input wire logic interrupt_acknowledge_n,
    input wire logic interrupt_request_input_n,
    input wire logic global_operation_input_n,
    input wire logic mapped_strobe_input_n,
    input wire logic fault_line_input_n,
    input wire logic none_matched_input,
    input wire logic table_wr,
    input wire logic [`MNT_FC_W-1:0] table_idx,
    input wire logic [`MNT_SPACE_W-1:0] table_data,
    input wire logic desc_wr,
    input wire logic [`MNT_IDX_W-1:0] desc_idx,
    input wire logic [`MNT_ADDR_W-1:0] desc_lba,
    input wire logic [`MNT_ADDR_W-1:0] desc_lam,
    input wire logic [`MNT_ADDR_W-1:0] desc_pba,
    input wire logic [`MNT_SPACE_W-1:0] desc_asn,
    input wire logic [`MNT_SPACE_W-1:0] desc_asm,
    input wire logic desc_en,
    input wire logic desc_wp,
    input wire logic desc_ie,
    output logic mapped_strobe_n,
    output logic hold_addr_n,
    output logic write_inhibit_n,
    output logic fault_out,
    output logic fault_oe_n,
    output logic none_matched_output,
    output logic [`MNT_ADDR_W-1:0] multiplexed_phys_bus_o,
    output logic multiplexed_phys_bus_oe_n,
    output logic start_master,
    output logic start_slave,
    output logic fault_flag,
    output logic double_fault_flag,
    output logic direction_bit,
    output logic [`MNT_CAUSE_W-1:0] cause_field,
    output logic [`MNT_RDP_W-1:0] result_descriptor_pointer,
    output logic [7:0] result_latch_high,
    output logic [7:0] result_latch_low,
    output logic [`MNT_SPACE_W-1:0] result_space_latch,
    output logic result_nonglobal,
    output logic [`MNT_N_DESC-1:0] used_flags,
    output logic [`MNT_N_DESC-1:0] modified_flags,
    output logic [`MNT_N_DESC-1:0] interrupt_pending_flag
);
    // ==========================================
    // Input synchronisers
    logic [`MNT_SYNC_W-1:0] sync_a;
    logic [`MNT_SYNC_W-1:0] sync_b;
    logic s_as, s_rw, s_cs, s_interrupt_acknowledge, s_irq, s_go, s_mas_in, s_fault_in, s_nm_in;
    logic [`MNT_FC_W-1:0] s_fc;
    logic [`MNT_ADDR_W-1:0] s_addr;
    logic rw_prev;

    // Two stages for every pin input
    always_ff @(posedge ref_clk) begin
        sync_a <= {as_n, rw, fc, laddr, cs_n, interrupt_acknowledge_n,
                   interrupt_request_input_n, global_operation_input_n,
                   mapped_strobe_input_n, fault_line_input_n, none_matched_input};
        sync_b <= sync_a;
        rw_prev <= sync_b[27];
    end

    assign s_as = ~sync_b[28];
    assign s_rw = sync_b[27];
    assign s_fc = sync_b[26:23];
    assign s_addr = sync_b[22:7];
    assign s_cs = ~sync_b[6];
    assign s_interrupt_acknowledge = ~sync_b[5];
    assign s_irq = ~sync_b[4];
    assign s_go = ~sync_b[3];
    assign s_mas_in = ~sync_b[2];
    assign s_fault_in = ~sync_b[1];
    assign s_nm_in = sync_b[0];

    // ==========================================
    // Space table and descriptor store
    logic [`MNT_SPACE_W-1:0] space_tbl [0:`MNT_N_SPACE-1];
    logic [`MNT_ADDR_W-1:0] d_lba [0:`MNT_N_DESC-1];
    logic [`MNT_ADDR_W-1:0] d_lam [0:`MNT_N_DESC-1];
    logic [`MNT_ADDR_W-1:0] d_pba [0:`MNT_N_DESC-1];
    logic [`MNT_SPACE_W-1:0] d_asn [0:`MNT_N_DESC-1];
    logic [`MNT_SPACE_W-1:0] d_asm [0:`MNT_N_DESC-1];
    logic [`MNT_N_DESC-1:0] d_en, d_wp, d_ie;

    // Space table loads, cleared at reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            for (int i = 0; i < `MNT_N_SPACE; i++) begin
                space_tbl[i] <= `MNT_SPACE_RESET;
            end
        end else if (table_wr) begin
            space_tbl[table_idx] <= table_data;
        end
    end

    // Descriptor fields, no reset needed while disabled
    always_ff @(posedge ref_clk) begin
        if (desc_wr) begin
            d_lba[desc_idx] <= desc_lba;
            d_lam[desc_idx] <= desc_lam;
            d_pba[desc_idx] <= desc_pba;
            d_asn[desc_idx] <= desc_asn;
            d_asm[desc_idx] <= desc_asm;
        end
    end

    // Descriptor control bits
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            d_en <= '0;
            d_wp <= '0;
            d_ie <= '0;
        end else if (desc_wr) begin
            d_en[desc_idx] <= desc_en;
            d_wp[desc_idx] <= desc_wp;
            d_ie[desc_idx] <= desc_ie;
        end
    end

    // ==========================================
    // Cycle capture and descriptor compare
    logic [`MNT_SPACE_W-1:0] cyc_space;
    logic [`MNT_ADDR_W-1:0] cyc_addr;
    logic cyc_rw;
    logic [`MNT_N_DESC-1:0] hit;
    logic [`MNT_ADDR_W-1:0] phys [0:`MNT_N_DESC-1];
    logic hit_any;
    logic [`MNT_IDX_W-1:0] hit_idx;
    logic [`MNT_ADDR_W-1:0] hit_phys;
    logic hit_wp;
    mnt_pkg::mnt_state_t state, next_state;

    // RULE1: space lookup by function code
    always_ff @(posedge ref_clk) begin
        if (state == mnt_pkg::MNT_IDLE) begin
            cyc_space <= space_tbl[s_fc];
            cyc_addr <= s_addr;
            cyc_rw <= s_rw;
        end
    end

    // RULE2: every descriptor sees the cycle
    for (genvar g = 0; g < `MNT_N_DESC; g++) begin : g_desc
        mnt_desc_match u_match (
            .enable(d_en[g]),
            .addr(cyc_addr),
            .space(cyc_space),
            .logical_base_address(d_lba[g]),
            .logical_address_mask(d_lam[g]),
            .physical_base_address(d_pba[g]),
            .space_number_field(d_asn[g]),
            .space_mask(d_asm[g]),
            .hit(hit[g]),
            .phys(phys[g])
        );
    end

    // Priority encoder, lowest descriptor wins
    always_comb begin
        hit_any = 1'b0;
        hit_idx = '0;
        hit_phys = '0;
        for (int i = `MNT_N_DESC - 1; i >= 0; i--) begin
            if (hit[i]) begin
                hit_any = 1'b1;
                hit_idx = i[`MNT_IDX_W-1:0];
                hit_phys = phys[i];
            end
        end
    end
    assign hit_wp = d_wp[hit_idx];

    // ==========================================
    // Events
    logic in_match, success, wv_now, rw_fall, local_wv, peer_fault, cause_undefined_segment;
    logic master_cond, slave_cond;
    logic loc_ok, loc_wp;
    logic [`MNT_IDX_W-1:0] loc_idx;
    logic [`MNT_CNT_W-1:0] cnt;

    assign in_match = state == mnt_pkg::MNT_MATCH;
    // RULE5: write to protected match is a violation
    assign wv_now = in_match & hit_any & ~cyc_rw & hit_wp;
    assign success = in_match & hit_any & ~wv_now;
    // RULE13: direction falls on protected match
    assign rw_fall = (state == mnt_pkg::MNT_FOLLOW) & s_as & loc_wp & rw_prev & ~s_rw;
    assign local_wv = wv_now | rw_fall;
    assign peer_fault = (state == mnt_pkg::MNT_NOMATCH) & ~s_mas_in & s_fault_in;
    assign cause_undefined_segment = (state == mnt_pkg::MNT_NOMATCH) & ~s_mas_in & ~s_fault_in & s_nm_in;
    assign master_cond = s_cs | (s_interrupt_acknowledge & s_irq);
    assign slave_cond = s_go;

    // Local match bookkeeping for the rest of the cycle
    always_ff @(posedge ref_clk) begin
        if (rst || state == mnt_pkg::MNT_IDLE) begin
            loc_ok <= 1'b0;
            loc_wp <= 1'b0;
            loc_idx <= '0;
        end else if (in_match && hit_any) begin
            loc_ok <= success;
            loc_wp <= hit_wp;
            loc_idx <= hit_idx;
        end
    end

    // ==========================================
    // Sequencer
    always_comb begin
        next_state = state;
        case (state)
            mnt_pkg::MNT_IDLE: if (s_as) next_state = mnt_pkg::MNT_MATCH;
            mnt_pkg::MNT_MATCH: begin
                if (!hit_any) next_state = mnt_pkg::MNT_NOMATCH;
                else if (wv_now) next_state = mnt_pkg::MNT_FAULT;
                else next_state = mnt_pkg::MNT_XLATE;
            end
            mnt_pkg::MNT_XLATE: if (cnt == 3'h2) next_state = mnt_pkg::MNT_FOLLOW;
            mnt_pkg::MNT_FOLLOW: begin
                // RULE11: strobe gone ends the cycle
                if (!s_as) next_state = mnt_pkg::MNT_IDLE;
                else if (rw_fall) next_state = mnt_pkg::MNT_FAULT;
                else if (master_cond || slave_cond) next_state = mnt_pkg::MNT_OPER;
            end
            mnt_pkg::MNT_OPER: if (!s_as) next_state = mnt_pkg::MNT_IDLE;
            mnt_pkg::MNT_NOMATCH: begin
                // RULE18: wait on peer lines
                if (!s_as) next_state = mnt_pkg::MNT_IDLE;
                // RULE19: peer strobe resumes
                else if (s_mas_in || peer_fault) next_state = mnt_pkg::MNT_FOLLOW;
                else if (cause_undefined_segment) next_state = mnt_pkg::MNT_USA;
            end
            mnt_pkg::MNT_USA: begin
                if (cnt == `MNT_ALL_HOLD_CLKS - 3'h1) next_state = mnt_pkg::MNT_FAULT;
            end
            mnt_pkg::MNT_FAULT: begin
                // RULE16: minimum five clocks, then wait for strobe
                if (cnt >= `MNT_FAULT_CLKS - 3'h1 && !s_as) next_state = mnt_pkg::MNT_IDLE;
            end
            default: next_state = mnt_pkg::MNT_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (rst) state <= mnt_pkg::MNT_IDLE;
        else state <= next_state;
    end

    // Clocks spent in the current state
    always_ff @(posedge ref_clk) begin
        if (rst || next_state != state) cnt <= '0;
        else if (cnt != 3'h7) cnt <= cnt + 3'h1;
    end

    // ==========================================
    // Bus strobes and physical bus
    logic xl_next;
    assign xl_next = next_state inside {mnt_pkg::MNT_XLATE, mnt_pkg::MNT_FOLLOW,
                                        mnt_pkg::MNT_OPER};

    // RULE10: drive address, strobe, hold, then float
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mapped_strobe_n <= 1'b1;
            hold_addr_n <= 1'b1;
            multiplexed_phys_bus_oe_n <= 1'b1;
            multiplexed_phys_bus_o <= '0;
        end else begin
            // RULE9: only a good local match raises the strobe
            mapped_strobe_n <= ~(loc_ok & xl_next & ~in_match);
            hold_addr_n <= ~(loc_ok & xl_next & ~in_match &
                             ~(state == mnt_pkg::MNT_XLATE && cnt == 3'h0));
            multiplexed_phys_bus_oe_n <= ~(next_state == mnt_pkg::MNT_XLATE);
            // RULE6: translated address onto the bus
            if (success) multiplexed_phys_bus_o <= hit_phys;
        end
    end

    // RULE8: inhibit writes on protected read cycles
    always_ff @(posedge ref_clk) begin
        if (rst || next_state == mnt_pkg::MNT_IDLE) write_inhibit_n <= 1'b1;
        else if ((success && hit_wp && cyc_rw) || local_wv) write_inhibit_n <= 1'b0;
    end

    // RULE22: none-matched held, released on the same clock that the fault pulse starts
    always_ff @(posedge ref_clk) begin
        if (rst) none_matched_output <= 1'b0;
        else none_matched_output <= next_state inside {mnt_pkg::MNT_NOMATCH,
                                                       mnt_pkg::MNT_USA};
    end

    // RULE16: open-drain fault pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_out <= 1'b0;
            fault_oe_n <= 1'b1;
        end else begin
            fault_out <= 1'b0;
            fault_oe_n <= ~(next_state == mnt_pkg::MNT_FAULT);
        end
    end

    // RULE12: hand off to master or slave operation
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            start_master <= 1'b0;
            start_slave <= 1'b0;
        end else begin
            start_master <= (state == mnt_pkg::MNT_FOLLOW) & s_as & ~rw_fall & master_cond;
            start_slave <= (state == mnt_pkg::MNT_FOLLOW) & s_as & ~rw_fall & ~master_cond &
                           slave_cond;
        end
    end

    // ==========================================
    // Status and result latches
    logic any_fault;
    assign any_fault = local_wv | peer_fault | cause_undefined_segment;

    // RULE14: fault flags and result pointer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fault_flag <= 1'b0;
            double_fault_flag <= 1'b0;
            result_descriptor_pointer <= `MNT_RDP_RESET;
        end else begin
            if (any_fault) begin
                fault_flag <= 1'b1;
                double_fault_flag <= double_fault_flag | fault_flag;
            end
            if (local_wv) begin
                result_descriptor_pointer <= {3'h0, in_match ? hit_idx : loc_idx};
            end
        end
    end

    // RULE15: direction and cause capture
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            direction_bit <= 1'b0;
            cause_field <= `MNT_CAUSE_NONE;
        end else if (local_wv) begin
            direction_bit <= in_match ? cyc_rw : s_rw;
            cause_field <= `MNT_CAUSE_WV;
        end else if (peer_fault) begin
            // RULE20: violation was elsewhere
            direction_bit <= s_rw;
            cause_field <= `MNT_CAUSE_NONE;
        end else if (cause_undefined_segment) begin
            // RULE21: undefined segment
            direction_bit <= s_rw;
            cause_field <= `MNT_CAUSE_USA;
        end
    end

    // RULE17: latch faulting address and space
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_latch_high <= 8'h00;
            result_latch_low <= 8'h00;
            result_space_latch <= '0;
            result_nonglobal <= 1'b0;
        end else if (local_wv || cause_undefined_segment) begin
            result_latch_high <= cyc_addr[15:8];
            result_latch_low <= cyc_addr[7:0];
            result_space_latch <= cyc_space;
            result_nonglobal <= 1'b1;
        end
    end

    // RULE7: segment status, set wins over a load
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            used_flags <= '0;
            modified_flags <= '0;
            interrupt_pending_flag <= '0;
        end else begin
            if (desc_wr) begin
                used_flags[desc_idx] <= 1'b0;
                modified_flags[desc_idx] <= 1'b0;
                interrupt_pending_flag[desc_idx] <= 1'b0;
            end
            if (success) begin
                used_flags[hit_idx] <= 1'b1;
                if (!cyc_rw) modified_flags[hit_idx] <= 1'b1;
                if (d_ie[hit_idx]) interrupt_pending_flag[hit_idx] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Checks
    logic [`MNT_ADDR_W-1:0] exp_phys;
    assign exp_phys = (cyc_addr & ~d_lam[hit_idx]) | (d_pba[hit_idx] & d_lam[hit_idx]);

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    chk_fault_length: assert property ($fell(fault_oe_n) |-> !fault_oe_n[*5]) // RULE16
        else $error("fault pulse shorter than five clocks");
    chk_fault_strobe: assert property ((state == mnt_pkg::MNT_FAULT && s_as) |=> !fault_oe_n) // RULE16
        else $error("fault released while strobe held");
    chk_strobe_order: assert property ($fell(mapped_strobe_n) |-> !multiplexed_phys_bus_oe_n
        ##1 !hold_addr_n ##1 multiplexed_phys_bus_oe_n) // RULE10
        else $error("strobe, hold, float order broken");
    chk_wv_no_strobe: assert property (wv_now |=> mapped_strobe_n[*2]) // RULE9
        else $error("mapped strobe on protected write");
    chk_inhibit_read: assert property ((success && hit_wp && cyc_rw) |=> !write_inhibit_n) // RULE8
        else $error("write inhibit missing on protected read");
    chk_phys_form: assert property (success |=> multiplexed_phys_bus_o == $past(exp_phys)) // RULE6
        else $error("physical address formed wrongly");
    chk_used_set: assert property (success |=> used_flags[$past(hit_idx)]) // RULE7
        else $error("used flag not set");
    chk_wv_status: assert property (local_wv |=> fault_flag && cause_field == `MNT_CAUSE_WV
        && result_nonglobal) // RULE15
        else $error("write violation status wrong");
    chk_peer_cause: assert property (peer_fault |=> fault_flag && cause_field == `MNT_CAUSE_NONE) // RULE20
        else $error("peer fault status wrong");
    chk_peer_release: assert property ((state == mnt_pkg::MNT_NOMATCH && s_mas_in && s_as)
        |=> !none_matched_output) // RULE19
        else $error("none-matched kept after peer strobe");
    chk_usa_hold: assert property ($rose(state == mnt_pkg::MNT_USA) |-> none_matched_output[*2]
        ##1 (!none_matched_output && !fault_oe_n)) // RULE22
        else $error("none-matched hold or fault timing wrong");
    chk_idle_return: assert property ((state == mnt_pkg::MNT_FOLLOW && !s_as)
        |=> state == mnt_pkg::MNT_IDLE) // RULE11
        else $error("no return to idle after strobe");

    cov_success: cover property (success ##[1:10] start_master);
    cov_usa: cover property (cause_undefined_segment ##[1:10] !fault_oe_n);
    cov_rw_fall: cover property (rw_fall);
    cov_peer: cover property (peer_fault);
endmodule

// File: tb_mnt_translate.sv
`timescale 1ns/1ns

// ==========================================
// Bench for translation, protection faults and peer lines
module tb_mnt_translate;
    typedef struct {logic [3:0] f; logic [15:0] a; logic r; logic [1:0] m;
        logic [15:0] p; logic w;} mnt_row_t;
    logic ref_clk = 0, rst = 1, as_n = 1, rw = 1, cs_n = 1, table_wr = 0, desc_wr = 0;
    logic interrupt_acknowledge_n = 1, interrupt_request_input_n = 1;
    logic global_operation_input_n = 1, desc_en = 1, desc_wp = 0, desc_ie = 0;
    logic [3:0] fc = 0, table_idx = 0;
    logic [4:0] desc_idx = 0;
    logic [7:0] table_data = 0, desc_asn = 0, desc_asm = 0;
    logic [15:0] laddr = 0, desc_lba = 0, desc_lam = 16'hFF00, desc_pba = 0;
    logic [1:0] mode = 0;
    logic mapped_strobe_n, hold_addr_n, write_inhibit_n, fault_out, fault_oe_n, pmas_n, pflt_n;
    logic none_matched_output, multiplexed_phys_bus_oe_n, start_master, start_slave, pall;
    logic fault_flag, double_fault_flag, direction_bit, result_nonglobal;
    logic [15:0] multiplexed_phys_bus_o;
    logic [3:0] cause_field;
    logic [7:0] result_descriptor_pointer, result_latch_high, result_latch_low;
    logic [7:0] result_space_latch;
    logic [31:0] used_flags, modified_flags, interrupt_pending_flag;
    // Wired shared lines
    wire mapped_strobe_input_n = pmas_n & mapped_strobe_n;
    wire fault_line_input_n = pflt_n & (fault_oe_n | fault_out);
    wire none_matched_input = pall & none_matched_output;
    int errors = 0, checks = 0, i, n;
    mnt_row_t rows [4] = '{'{4'h1, 16'h1234, 1'h1, 2'h0, 16'hAB34, 1'h1},
        '{4'h1, 16'h1277, 1'h0, 2'h0, 16'hAB77, 1'h1},
        '{4'h5, 16'h3456, 1'h1, 2'h0, 16'hCD56, 1'h0},
        '{4'h5, 16'h1200, 1'h1, 2'h1, 16'h0000, 1'h1}};

    mnt_translate mnt_translate_inst (.*);
    mnt_peer mnt_peer_inst (.ref_clk, .as_n, .mode, .all_line(none_matched_input),
        .mas_n(pmas_n), .flt_n(pflt_n), .all_out(pall));

    // Clock
    always #10 ref_clk = ~ref_clk;

    // ==========================================
    // Helpers
    task automatic chk(input string s, input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic tk(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic go(input logic [3:0] f, input logic [15:0] a, input logic r,
            input logic [1:0] m);
        fc <= f;
        laddr <= a;
        rw <= r;
        mode <= m;
        tk(2);
        as_n <= 0;
        n = 0;
    endtask
    task automatic stop;
        as_n <= 1;
        tk(8);
    endtask
    task automatic ld(input logic [4:0] x, input logic [15:0] b, input logic [15:0] p,
            input logic [7:0] s, input logic [7:0] k, input logic w, input logic ie);
        desc_wr <= 1;
        desc_idx <= x;
        desc_lba <= b;
        desc_pba <= p;
        desc_asn <= s;
        desc_asm <= k;
        desc_wp <= w;
        desc_ie <= ie;
        tk(1);
        desc_wr <= 0;
        tk(1);
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        tk(5);
        rst <= 0;
        tk(1);
        chk("rdp_rst", result_descriptor_pointer, 8'h80);
        ld(5'h0, 16'h1200, 16'hAB00, 8'h11, 8'hFF, 0, 1);
        ld(5'h1, 16'h3400, 16'hCD00, 8'h05, 8'h0F, 1, 0);
        table_wr <= 1;
        table_idx <= 4'h1;
        table_data <= 8'h11;
        tk(1);
        table_idx <= 4'h5;
        table_data <= 8'hA5;
        tk(1);
        table_wr <= 0;
        foreach (rows[j]) begin
            cs_n <= rows[j].w;
            go(rows[j].f, rows[j].a, rows[j].r, rows[j].m);
            while (mapped_strobe_n && pmas_n && n < 30) begin
                tk(1);
                n++;
            end
            if (rows[j].m == 2'h0) begin
                chk("pad_oe", multiplexed_phys_bus_oe_n, 0);
                chk("pad", multiplexed_phys_bus_o, rows[j].p);
                tk(3);
                chk("mst", start_master, !rows[j].w);
                chk("hold", hold_addr_n, 0);
                chk("winh", write_inhibit_n, rows[j].w);
            end else begin
                chk("nm_hi", none_matched_output, 1);
                tk(6);
                chk("nm_lo", none_matched_output, 0);
            end
            stop;
            chk("idle", mapped_strobe_n & hold_addr_n, 1);
        end
        chk("used", used_flags[1:0], 2'h3);
        chk("mod", modified_flags[1:0], 2'h1);
        chk("pend", interrupt_pending_flag[1:0], 2'h1);
        // Protected write, then a protected read whose direction falls to write; the second doubles the fault
        for (i = 0; i < 2; i++) begin
            go(4'h5, 16'h3456, i[0], 0);
            while (fault_oe_n && n < 30) begin
                tk(1);
                n++;
                if (n == 6) rw <= 0;
            end
            as_n <= 1;
            chk("mas_wp", mapped_strobe_n, 1);
            chk("cause", cause_field, 1);
            chk("dir", direction_bit, 0);
            chk("rdp", result_descriptor_pointer, 8'h01);
            chk("df", double_fault_flag, i[0]);
            chk("lat", {result_latch_high, result_latch_low}, 16'h3456);
            chk("spc", {result_space_latch, 7'h0, result_nonglobal}, 16'hA501);
            n = 0;
            while (!fault_oe_n && n < 30) begin
                tk(1);
                n++;
            end
            chk("flt_len", n >= 5 && n <= 6, 1);
            tk(8);
        end
        // Undefined segment, then a peer fault clears the cause
        go(4'h1, 16'h5600, 1, 3);
        while (fault_oe_n && n < 40) begin
            tk(1);
            n++;
        end
        chk("nm_rel", none_matched_output, 0);
        chk("cause_u", cause_field, 2);
        chk("dir_u", direction_bit, 1);
        chk("lat_u", {result_latch_high, result_latch_low}, 16'h5600);
        chk("spc_u", result_space_latch, 8'h11);
        stop;
        go(4'h1, 16'h5600, 0, 2);
        while (cause_field !== 4'h0 && n < 40) begin
            tk(1);
            n++;
        end
        chk("cause_p", cause_field, 0);
        chk("dir_p", direction_bit, 0);
        stop;
        report_and_stop;
    end

    // Watchdog against a hung handshake
    initial begin
        #200000;
        errors++;
        report_and_stop;
    end
endmodule
